//--- rtl/lfdfs_pkg.sv
// Shared types and constants for the lamp dimming and fault sequencer.
// Assumes comparator outputs arrive as plain logic levels from the
// analog front end, asynchronous to clk_in.

`default_nettype none

package lfdfs_pkg;

    // ------------------------------------------------------------------
    // Startup stages, ordered by rising startup-timing voltage
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_OFF     = 3'h0,
        ST_CORE    = 3'h1,
        ST_DRIVE   = 3'h2,
        ST_DETECT  = 3'h3,
        ST_DIMMING = 3'h4
    } lfdfs_stage_t;

    // ------------------------------------------------------------------
    // Comparator bundles
    // ------------------------------------------------------------------
    // Startup-timing comparators: above 0.5 V, 1 V, 3 V, 4 V
    typedef struct packed
    {
        logic above_0v5;
        logic above_1v0;
        logic above_3v0;
        logic above_4v0;
    } lfdfs_startup_t;

    // Dimming ramp comparators and digital dimming pins
    typedef struct packed
    {
        logic ramp_at_peak;
        logic ramp_at_valley;
        logic ramp_above_dim;
        logic dim_below_valley;
        logic brightness_control;
        logic dimming_sync;
    } lfdfs_dim_t;

    // One resonant tank: cycle marker and the 7.8 V drop comparator
    typedef struct packed
    {
        logic tank_cycle;
        logic tank_drop;
    } lfdfs_tank_t;

    // ------------------------------------------------------------------
    // Counts and register map
    // ------------------------------------------------------------------
    localparam int          CH_NUM         = 2;
    localparam int          CNT_W          = 5;
    localparam logic [4:0]  OPEN_LAMP_TRIP = 5'h10;
    localparam logic [4:0]  CNT_RESET      = 5'h00;

    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_COUNT      = 4'h8;
    localparam logic        CTRL_SYNC_RST  = 1'h1;

endpackage

`default_nettype wire

//--- rtl/lfdfs_core.sv
// Digital core of a dual-channel backlight lamp controller: startup
// stepping, dimming mode latch, dimming PWM, open-lamp fault latch.
// Assumes all comparator inputs are asynchronous and a power-on reset
// drives rst_in; register port is a plain strobe port on clk_in.
//
// Behaviour
// - Latch dimming mode from sync at crossing
// - Digital mode: brightness input gates outputs directly
// - Analog mode: brightness sets lamp-on fraction
// - PWM on at discharge, off at crossing
// - Sync pulse ends charge, starts discharge
// - Stage enables at 0.5 V and 1 V
// - Detection off until open-lamp enable level
// - Count up on tank cycle with drop
// - Count down on tank cycle without drop
// - Count sixteen latches fault, outputs off
// - Fault cleared only by power cycle
// - Detection enabled only above 3.0 V
// - Dimming enabled only above 4.0 V

`timescale 1ns/10ps
`default_nettype none

module lfdfs_core
(
    input  wire logic                    clk_in,      // 250 MHz clock
    input  wire logic                    rst_in,      // Sync reset, high
    input  wire lfdfs_pkg::lfdfs_startup_t startup_in, // Startup levels
    input  wire lfdfs_pkg::lfdfs_dim_t   dim_in,      // Dimming inputs
    input  wire lfdfs_pkg::lfdfs_tank_t  tank_a_in,   // Tank A sense
    input  wire lfdfs_pkg::lfdfs_tank_t  tank_b_in,   // Tank B sense
    input  wire logic [3:0]              addr_in,     // Register address
    input  wire logic [31:0]             wdata_in,    // Write data
    input  wire logic                    wr_in,       // Write strobe
    input  wire logic                    rd_in,       // Read strobe
    output logic [31:0]                  rdata_out,   // Read data
    output logic                         gate_drive_a_out, // Channel A
    output logic                         gate_drive_b_out, // Channel B
    output logic                         ramp_discharge_out, // Ramp dir
    output logic                         dim_pwm_out, // Dimming PWM
    output logic                         fault_out,   // Open-lamp fault
    output logic                         digital_mode_out // Digital mode
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int PIN_W = 14;

    logic [PIN_W-1:0]          pin_raw;
    logic [PIN_W-1:0]          pin_meta_r;
    logic [PIN_W-1:0]          pin_sync_r;
    lfdfs_pkg::lfdfs_startup_t startup_s;
    lfdfs_pkg::lfdfs_dim_t     dim_s;
    lfdfs_pkg::lfdfs_tank_t    tank_s [lfdfs_pkg::CH_NUM];

    assign pin_raw = {startup_in, dim_in, tank_a_in, tank_b_in};

    always_ff @(posedge clk_in)
    begin
        pin_meta_r <= pin_raw;
        pin_sync_r <= pin_meta_r;
    end

    assign startup_s = pin_sync_r[13:10];
    assign dim_s     = pin_sync_r[9:4];
    assign tank_s[0] = pin_sync_r[3:2];
    assign tank_s[1] = pin_sync_r[1:0];

    // ------------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------------
    logic                    above_4v0_prev_r;
    logic                    sync_prev_r;
    logic                    dim_cross;
    logic                    sync_pulse;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            above_4v0_prev_r <= 1'h0;
            sync_prev_r      <= 1'h0;
        end
        else
        begin
            above_4v0_prev_r <= startup_s.above_4v0;
            sync_prev_r      <= dim_s.dimming_sync;
        end
    end

    assign dim_cross  = startup_s.above_4v0 & ~above_4v0_prev_r;
    assign sync_pulse = dim_s.dimming_sync & ~sync_prev_r;

    // ------------------------------------------------------------------
    // Startup stage
    // ------------------------------------------------------------------
    lfdfs_pkg::lfdfs_stage_t stage_r;
    lfdfs_pkg::lfdfs_stage_t stage_nxt;
    logic                    core_on;
    logic                    drive_on;
    logic                    detect_on;
    logic                    dimming_on;

    // Past the 0.5 V check, levels are taken highest first so a slow
    // comparator cannot hold the stage below a level already reached
    always_comb
    begin
        if (!startup_s.above_0v5)
            stage_nxt = lfdfs_pkg::ST_OFF;
        else if (startup_s.above_4v0)
            stage_nxt = lfdfs_pkg::ST_DIMMING;
        else if (startup_s.above_3v0)
            stage_nxt = lfdfs_pkg::ST_DETECT;
        else if (startup_s.above_1v0)
            stage_nxt = lfdfs_pkg::ST_DRIVE;
        else
            stage_nxt = lfdfs_pkg::ST_CORE;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            stage_r <= lfdfs_pkg::ST_OFF;
        else
            stage_r <= stage_nxt;
    end

    always_comb
    begin
        core_on    = 1'h0;
        drive_on   = 1'h0;
        detect_on  = 1'h0;
        dimming_on = 1'h0;
        unique case (stage_r)
            lfdfs_pkg::ST_OFF:
            begin
                core_on = 1'h0;
            end
            lfdfs_pkg::ST_CORE:
            begin
                core_on = 1'h1;
            end
            lfdfs_pkg::ST_DRIVE:
            begin
                core_on  = 1'h1;
                drive_on = 1'h1;
            end
            lfdfs_pkg::ST_DETECT:
            begin
                core_on   = 1'h1;
                drive_on  = 1'h1;
                detect_on = 1'h1;
            end
            lfdfs_pkg::ST_DIMMING:
            begin
                core_on    = 1'h1;
                drive_on   = 1'h1;
                detect_on  = 1'h1;
                dimming_on = 1'h1;
            end
            default:
            begin
                core_on = 1'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic sync_accept_r;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            sync_accept_r <= lfdfs_pkg::CTRL_SYNC_RST;
        else if (wr_in && addr_in == lfdfs_pkg::REG_CTRL)
            sync_accept_r <= wdata_in[0];
    end

    // ------------------------------------------------------------------
    // Dimming mode latch
    // ------------------------------------------------------------------
    logic digital_r;

    // Re-latched on every upward crossing while the core is on, so apart
    // from reset a dip below the threshold is the only way to change mode
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            digital_r <= 1'h0;
        else if (core_on && dim_cross)
            digital_r <= dim_s.dimming_sync;
    end

    // ------------------------------------------------------------------
    // Dimming oscillator and PWM
    // ------------------------------------------------------------------
    logic discharge_r;
    logic pwm_r;
    logic charge_end;
    logic charge_start;

    // Sync is honoured only in the charge phase; a pulse arriving during
    // discharge would otherwise shorten the lamp-on time
    assign charge_end   = ~discharge_r &
                          (dim_s.ramp_at_peak |
                           (sync_pulse & sync_accept_r));
    assign charge_start = discharge_r & dim_s.ramp_at_valley;

    always_ff @(posedge clk_in)
    begin
        if (rst_in || !core_on)
            discharge_r <= 1'h0;
        else if (charge_end)
            discharge_r <= 1'h1;
        else if (charge_start)
            discharge_r <= 1'h0;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in || !core_on)
            pwm_r <= 1'h0;
        else if (charge_end)
            pwm_r <= 1'h1;
        else if (charge_start && dim_s.dim_below_valley)
            pwm_r <= 1'h0;
        else if (!discharge_r && dim_s.ramp_above_dim)
            pwm_r <= 1'h0;
    end

    // ------------------------------------------------------------------
    // Open-lamp counters, one per channel
    // ------------------------------------------------------------------
    logic [lfdfs_pkg::CNT_W-1:0]  cnt_r [lfdfs_pkg::CH_NUM];
    logic [lfdfs_pkg::CH_NUM-1:0] trip;
    logic                         fault_r;

    genvar ch;
    generate
        for (ch = 0; ch < lfdfs_pkg::CH_NUM; ch++)
        begin : g_chan
            logic cycle_prev_r;
            logic cycle_pulse;

            assign cycle_pulse = tank_s[ch].tank_cycle & ~cycle_prev_r;

            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                    cycle_prev_r <= 1'h0;
                else
                    cycle_prev_r <= tank_s[ch].tank_cycle;
            end

            always_ff @(posedge clk_in)
            begin
                if (rst_in || !core_on)
                    cnt_r[ch] <= lfdfs_pkg::CNT_RESET;
                else if (detect_on && !fault_r && cycle_pulse)
                begin
                    if (tank_s[ch].tank_drop)
                        cnt_r[ch] <= cnt_r[ch] + 5'h01;
                    else if (cnt_r[ch] != lfdfs_pkg::CNT_RESET)
                        cnt_r[ch] <= cnt_r[ch] - 5'h01;
                end
            end

            assign trip[ch] = (cnt_r[ch] == lfdfs_pkg::OPEN_LAMP_TRIP);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Fault latch
    // ------------------------------------------------------------------
    // Only reset or a discharged startup-timing input clears it; no register
    // write or other pin touches it
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !core_on)
            fault_r <= 1'h0;
        else if (|trip)
            fault_r <= 1'h1;
    end

    // ------------------------------------------------------------------
    // Gate drive outputs
    // ------------------------------------------------------------------
    logic dim_gate;
    logic drive_a_r;
    logic drive_b_r;

    // Below the dimming level the lamps run at full duty
    assign dim_gate = !dimming_on ? 1'h1 :
                      digital_r   ? dim_s.brightness_control :
                                    pwm_r;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            drive_a_r <= 1'h0;
            drive_b_r <= 1'h0;
        end
        else
        begin
            drive_a_r <= drive_on & ~fault_r & ~(|trip) & dim_gate;
            drive_b_r <= drive_on & ~fault_r & ~(|trip) & dim_gate;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rdata_out <= 32'h0;
        else if (rd_in)
        begin
            unique case (addr_in)
                lfdfs_pkg::REG_CTRL:
                    rdata_out <= {31'h0, sync_accept_r};
                lfdfs_pkg::REG_STATUS:
                    rdata_out <= {24'h0, digital_r, fault_r, pwm_r,
                                  discharge_r, 1'h0, stage_r};
                lfdfs_pkg::REG_COUNT:
                    rdata_out <= {19'h0, cnt_r[1], 3'h0, cnt_r[0]};
                default:
                    rdata_out <= 32'h0;
            endcase
        end
        else
            rdata_out <= 32'h0;
    end

    assign gate_drive_a_out   = drive_a_r;
    assign gate_drive_b_out   = drive_b_r;
    assign ramp_discharge_out = discharge_r;
    assign dim_pwm_out        = pwm_r;
    assign fault_out          = fault_r;
    assign digital_mode_out   = digital_r;

endmodule

`default_nettype wire

//--- testbench/lfdfs_chk.sv
// Port checker for the lamp dimming and fault sequencer core.
// Assumes pin levels reach the outputs within six clocks.
`timescale 1ns/10ps
`default_nettype none
module lfdfs_chk
(
    input wire logic                      clk_in,             // Clock
    input wire logic                      rst_in,             // Reset
    input wire lfdfs_pkg::lfdfs_startup_t startup_in,         // Levels
    input wire lfdfs_pkg::lfdfs_dim_t     dim_in,             // Dimming
    input wire lfdfs_pkg::lfdfs_tank_t    tank_a_in,          // Tank A
    input wire lfdfs_pkg::lfdfs_tank_t    tank_b_in,          // Tank B
    input wire logic [3:0]                addr_in,            // Address
    input wire logic [31:0]               wdata_in,           // Wr data
    input wire logic                      wr_in,              // Write
    input wire logic                      rd_in,              // Read
    input wire logic [31:0]               rdata_out,          // Rd data
    input wire logic                      gate_drive_a_out,   // Drive A
    input wire logic                      gate_drive_b_out,   // Drive B
    input wire logic                      ramp_discharge_out, // Ramp
    input wire logic                      dim_pwm_out,        // PWM
    input wire logic                      fault_out,          // Fault
    input wire logic                      digital_mode_out    // Mode
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // Six cycles cover the synchroniser, stage and drive registers
    sequence s_dig(lvl);
        (startup_in.above_4v0 && digital_mode_out && !fault_out
            && dim_in.brightness_control == lvl) [*6];
    endsequence

    a_fault_kills_drive: assert property
        (fault_out |-> !gate_drive_a_out && !gate_drive_b_out)
        else $error("gate drive active while faulted");
    a_fault_holds: assert property
        (startup_in.above_0v5 [*5] ##0 fault_out |=> fault_out)
        else $error("fault cleared while powered");
    a_off_idle: assert property
        ((!startup_in.above_0v5) [*6] |->
            !gate_drive_a_out && !gate_drive_b_out && !fault_out)
        else $error("outputs active while disabled");
    a_drive_needs_level: assert property
        ((!startup_in.above_1v0) [*6] |->
            !gate_drive_a_out && !gate_drive_b_out)
        else $error("drive on below drive level");
    a_no_early_trip: assert property
        ((!startup_in.above_3v0) [*6] |-> !$rose(fault_out))
        else $error("fault raised below detect level");
    a_dig_on: assert property
        (s_dig(1'b1) |-> gate_drive_a_out && gate_drive_b_out)
        else $error("digital mode drive not on");
    a_dig_off: assert property
        (s_dig(1'b0) |-> !gate_drive_a_out && !gate_drive_b_out)
        else $error("digital mode drive not off");
    // The mode flop follows the pins three samples late; a drop of the
    // mode by reset is not a crossing and is left out
    a_mode_latch: assert property
        ($changed(digital_mode_out) && !$past(rst_in) |->
            $past(startup_in.above_4v0, 3)
            && !$past(startup_in.above_4v0, 4)
            && digital_mode_out == $past(dim_in.dimming_sync, 3))
        else $error("mode changed without crossing");
    a_pwm_at_discharge: assert property
        ($rose(ramp_discharge_out) && !digital_mode_out |-> dim_pwm_out)
        else $error("pwm off at discharge start");
endmodule

bind lfdfs_core lfdfs_chk chk_u
(
    .clk_in(clk_in), .rst_in(rst_in), .startup_in(startup_in),
    .dim_in(dim_in), .tank_a_in(tank_a_in), .tank_b_in(tank_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .gate_drive_a_out(gate_drive_a_out),
    .gate_drive_b_out(gate_drive_b_out),
    .ramp_discharge_out(ramp_discharge_out), .dim_pwm_out(dim_pwm_out),
    .fault_out(fault_out), .digital_mode_out(digital_mode_out)
);
`default_nettype wire

//--- testbench/lfdfs_far.sv
// Resonant tank sense model for both channels, making tank cycles on call.
// Assumes the caller waits for one burst to end before the next.
`timescale 1ns/10ps
`default_nettype none
module lfdfs_far
(
    input  wire logic                 clk_in,     // Clock
    output var lfdfs_pkg::lfdfs_tank_t tank_a_out, // Tank A
    output var lfdfs_pkg::lfdfs_tank_t tank_b_out  // Tank B
);
    initial
    begin
        tank_a_out = '0;
        tank_b_out = '0;
    end

    // Drop flag is true only around the cycle edge and inverted elsewhere,
    // so a core that samples it late counts the wrong way
    task automatic burst(input int n, input logic da, db);
        repeat (n)
        begin
            @(posedge clk_in);
            tank_a_out.tank_drop <= da;
            tank_b_out.tank_drop <= db;
            repeat (2) @(posedge clk_in);
            tank_a_out.tank_cycle <= 1'b1;
            tank_b_out.tank_cycle <= 1'b1;
            repeat (2) @(posedge clk_in);
            tank_a_out.tank_drop <= !da;
            tank_b_out.tank_drop <= !db;
            repeat (2) @(posedge clk_in);
            tank_a_out.tank_cycle <= 1'b0;
            tank_b_out.tank_cycle <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench: register port, startup stages, dimming modes,
// ramp PWM and the open-lamp fault latch. Assumes the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                      clk_in = 1'b0;
    logic                      rst_in = 1'b1;
    lfdfs_pkg::lfdfs_startup_t stu = '0;
    lfdfs_pkg::lfdfs_dim_t     brightness_control_input = '0;
    lfdfs_pkg::lfdfs_tank_t    ta;
    lfdfs_pkg::lfdfs_tank_t    tnb;
    logic [3:0]                addr = 4'h0;
    logic [31:0]               wdata = 32'h0;
    logic [31:0]               rdata;
    logic                      wr = 1'b0;
    logic                      rd = 1'b0;
    logic                      ga, gb, dis, pwm, flt, dmd;
    int                        n_errors = 0;
    int                        samples_checked = 0;

    lfdfs_core dut_u
    (
        .clk_in(clk_in), .rst_in(rst_in), .startup_in(stu), .dim_in(brightness_control_input),
        .tank_a_in(ta), .tank_b_in(tnb), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .gate_drive_a_out(ga),
        .gate_drive_b_out(gb), .ramp_discharge_out(dis), .dim_pwm_out(pwm),
        .fault_out(flt), .digital_mode_out(dmd)
    );
    lfdfs_far far_u
    (
        .clk_in(clk_in), .tank_a_out(ta), .tank_b_out(tnb)
    );

    initial
    begin
        forever #2 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic chb(input string nm, input logic e, g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic chd(input logic e);
        chb("drive a", e, ga);
        chb("drive b", e, gb);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [31:0] e);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    task automatic lvl(input int n);
        @(posedge clk_in);
        stu <= '{n > 0, n > 1, n > 2, n > 3};
        wt(10);
    endtask
    task automatic setd(input logic [5:0] v);
        @(posedge clk_in);
        brightness_control_input <= v;
        wt(8);
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_chk("ctrl", lfdfs_pkg::REG_CTRL, 32'h1);
        rd_chk("unmapped", 4'hc, 32'h0);
        wr_reg(lfdfs_pkg::REG_STATUS, 32'hff);
        rd_chk("status", lfdfs_pkg::REG_STATUS, 32'h0);
        for (int i = 1; i < 4; i++)
        begin
            lvl(i);
            rd_chk("stage", lfdfs_pkg::REG_STATUS, {29'h0, 3'(i)});
            chd(i > 1);
            far_u.burst(3, 1'b1, 1'b1);
            wt(4);
            rd_chk("count", lfdfs_pkg::REG_COUNT,
                   i > 2 ? 32'h0303 : 32'h0);
        end
        far_u.burst(5, 1'b1, 1'b0);
        wt(4);
        rd_chk("count", lfdfs_pkg::REG_COUNT, 32'h0008);
        far_u.burst(9, 1'b0, 1'b1);
        wt(4);
        rd_chk("count", lfdfs_pkg::REG_COUNT, 32'h0900);
        // Sync refused here, so the level set before the crossing is quiet
        wr_reg(lfdfs_pkg::REG_CTRL, 32'h0);
        rd_chk("ctrl", lfdfs_pkg::REG_CTRL, 32'h0);
        setd(6'b000001);
        lvl(4);
        chb("mode", 1'b1, dmd);
        rd_chk("status", lfdfs_pkg::REG_STATUS, 32'h84);
        setd(6'b000011);
        chd(1'b1);
        setd(6'b000001);
        chd(1'b0);
        lvl(3);
        setd(6'b000000);
        lvl(4);
        chb("mode", 1'b0, dmd);
        wr_reg(lfdfs_pkg::REG_CTRL, 32'h1);
        setd(6'b100000);
        chb("discharge", 1'b1, dis);
        chd(1'b1);
        setd(6'b010000);
        chb("pwm", 1'b1, pwm);
        setd(6'b001000);
        chb("pwm", 1'b0, pwm);
        chd(1'b0);
        setd(6'b100100);
        setd(6'b010100);
        chb("pwm", 1'b0, pwm);
        setd(6'b000001);
        chb("discharge", 1'b1, dis);
        setd(6'b010000);
        wr_reg(lfdfs_pkg::REG_CTRL, 32'h0);
        setd(6'b000000);
        setd(6'b000001);
        chb("refused sync", 1'b0, dis);
        setd(6'b100000);
        far_u.burst(6, 1'b0, 1'b1);
        wt(4);
        chb("fault", 1'b0, flt);
        chd(1'b1);
        far_u.burst(1, 1'b0, 1'b1);
        wt(4);
        chb("fault", 1'b1, flt);
        chd(1'b0);
        setd(6'b010010);
        wr_reg(lfdfs_pkg::REG_CTRL, 32'h1);
        chb("fault", 1'b1, flt);
        lvl(0);
        chb("fault", 1'b0, flt);
        rd_chk("count", lfdfs_pkg::REG_COUNT, 32'h0);
        // Accept bit cleared first, so the read below proves the reset
        wr_reg(lfdfs_pkg::REG_CTRL, 32'h0);
        @(posedge clk_in);
        rst_in <= 1'b1;
        @(posedge clk_in);
        rst_in <= 1'b0;
        rd_chk("ctrl", lfdfs_pkg::REG_CTRL, 32'h1);
        end_of_test();
    end

    // The sequence needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge clk_in);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
